// ---- bscps_top.sv ----
// Boot strap decode, configuration load sequencing and power states
// What this block does
// - Sample both straps before any configuration load
// - Then try loading config from EEPROM
// - No EEPROM answer: wait for host load
// - EEPROM addressed at seven-bit address 50h
// - Four pairs select unconditional sink policy
// - Four pairs select three-amp sink policy
// - Four pairs select one-and-half-amp sink policy
// - Four pairs select high-voltage negotiation policy
// - All other pairs select no-sink policy
// - Exactly one of Active, Idle, Sleep
// - Power states change without host command
// - Sleep watches attach and wakes on it
// - Idle only after quiet interval T
// - Ports get distinct addresses, A only in boot
`timescale 1ns/10ps
module bscps_top #(
   parameter int unsigned IDLE_CYCLES = bscps_pkg::IDLE_CYCLES,
   parameter int unsigned SLEEP_CYCLES = bscps_pkg::SLEEP_CYCLES
) (
   input wire logic mclk, // Core clock, 20 MHz
   input wire logic reset, // Synchronous reset, active high
   input wire logic [2:0] strap_input_one, // Decoded first strap level
   input wire logic [2:0] strap_input_two, // Decoded second strap level
   input wire logic eeprom_sda_in, // Eeprom data line level
   input wire logic eeprom_cfg_loaded, // Eeprom bundle fetch finished
   input wire logic host_cfg_loaded, // Host finished config load
   input wire logic activity, // Any PD, CC, GPIO, I2C or alert event
   input wire logic attach, // Type-C attach detected
   input wire logic circuits_busy, // Circuits require Active state
   output logic eeprom_scl_out, // Eeprom clock level
   output logic eeprom_scl_oe, // Eeprom clock drive enable
   output logic eeprom_sda_oe, // Eeprom data pull-low enable
   output logic [2:0] addr_index, // Address index 1 to 4, 0 for an undecoded pair
   output logic [2:0] policy, // Dead-battery sink policy
   output logic [6:0] port_a_addr, // Host port A address
   output logic [6:0] port_b_addr, // Host port B address
   output logic port_b_enable, // Port B address responds
   output logic sink_enable, // Sink path enable
   output logic sink_needs_3a, // Sink only if source offers 3.0A
   output logic sink_needs_1a5, // Sink only if source offers 1.5A
   output logic pd_enable, // Power delivery messaging enable
   output logic app_state, // In application firmware state
   output logic eeprom_present, // Eeprom answered its address
   output logic cfg_loaded, // Configuration loaded
   output logic [1:0] power_state // 0 active, 1 idle, 2 sleep
);
   typedef struct packed {
      logic [2:0] s1a;
      logic [2:0] s1b;
      logic [2:0] s2a;
      logic [2:0] s2b;
      logic [2:0] idx;
      logic [2:0] pol;
      bscps_pkg::bscps_boot_t boot;
      bscps_pkg::bscps_pwr_t pwr;
      logic [31:0] quiet;
      logic probe_go;
      logic present;
      logic loaded;
      logic act_a;
      logic act_b;
      logic att_a;
      logic att_b;
      logic [1:0] settle;
      logic sda_a;
      logic sda_b;
   } bscps_top_st_t;
   bscps_top_st_t s_q, s_d;
   logic probe_done, probe_acked;
   logic scl_w, scl_oe_w, sda_oe_w;

   // ************************************************
   // Strap decode
   // ************************************************
   function automatic logic [5:0] bscps_decode(input logic [2:0] a,
                                               input logic [2:0] b);
      logic [5:0] r;
      r = {3'h0, 3'(bscps_pkg::POL_NO_SINK)};
      unique case ({a, b})
         6'h3D: r = {3'h1, 3'(bscps_pkg::POL_UNCOND)};
         6'h2D: r = {3'h2, 3'(bscps_pkg::POL_UNCOND)};
         6'h10: r = {3'h3, 3'(bscps_pkg::POL_UNCOND)};
         6'h0F: r = {3'h4, 3'(bscps_pkg::POL_UNCOND)};
         6'h3C: r = {3'h1, 3'(bscps_pkg::POL_THREE_AMP)};
         6'h24: r = {3'h2, 3'(bscps_pkg::POL_THREE_AMP)};
         6'h18: r = {3'h3, 3'(bscps_pkg::POL_THREE_AMP)};
         6'h17: r = {3'h4, 3'(bscps_pkg::POL_THREE_AMP)};
         6'h3E: r = {3'h1, 3'(bscps_pkg::POL_ONE_HALF_AMP)};
         6'h36: r = {3'h2, 3'(bscps_pkg::POL_ONE_HALF_AMP)};
         6'h35: r = {3'h3, 3'(bscps_pkg::POL_ONE_HALF_AMP)};
         6'h37: r = {3'h4, 3'(bscps_pkg::POL_ONE_HALF_AMP)};
         6'h3B: r = {3'h1, 3'(bscps_pkg::POL_HIGH_VOLT)};
         6'h1B: r = {3'h2, 3'(bscps_pkg::POL_HIGH_VOLT)};
         6'h20: r = {3'h3, 3'(bscps_pkg::POL_HIGH_VOLT)};
         6'h1F: r = {3'h4, 3'(bscps_pkg::POL_HIGH_VOLT)};
         6'h38: r = {3'h1, 3'(bscps_pkg::POL_NO_SINK)};
         6'h00: r = {3'h2, 3'(bscps_pkg::POL_NO_SINK)};
         6'h30: r = {3'h3, 3'(bscps_pkg::POL_NO_SINK)};
         6'h2F: r = {3'h4, 3'(bscps_pkg::POL_NO_SINK)};
         default: r = {3'h0, 3'(bscps_pkg::POL_NO_SINK)};
      endcase
      return r;
   endfunction : bscps_decode

   // ************************************************
   // Eeprom probe engine
   // ************************************************
   bscps_probe u_probe (
      .mclk(mclk),
      .reset(reset),
      .start(s_q.probe_go),
      .sda_in(s_q.sda_b),
      .scl_out(scl_w),
      .scl_oe(scl_oe_w),
      .sda_oe(sda_oe_w),
      .done(probe_done),
      .acked(probe_acked)
   );

   // ************************************************
   // Sequencing and power states
   // ************************************************
   always_comb begin
      logic [5:0] dec;
      dec = bscps_decode(s_q.s1b, s_q.s2b);
      s_d = s_q;
      s_d.probe_go = 1'b0;
      s_d.s1a = strap_input_one;
      s_d.s1b = s_q.s1a;
      s_d.s2a = strap_input_two;
      s_d.s2b = s_q.s2a;
      s_d.act_a = activity;
      s_d.act_b = s_q.act_a;
      s_d.att_a = attach;
      s_d.att_b = s_q.att_a;
      s_d.sda_a = eeprom_sda_in;
      s_d.sda_b = s_q.sda_a;
      unique case (s_q.boot)
         bscps_pkg::BOOT_STRAP: begin
            // Both strap stages hold reset zeros until filled twice
            if (s_q.settle != 2'h2) begin
               s_d.settle = s_q.settle + 2'h1;
            end else begin
               s_d.idx = dec[5:3];
               s_d.pol = dec[2:0];
               s_d.boot = bscps_pkg::BOOT_PROBE;
               s_d.probe_go = 1'b1;
            end
         end
         bscps_pkg::BOOT_PROBE: begin
            if (probe_done) begin
               s_d.present = probe_acked;
               // No answer leaves the host as the only loader
               s_d.boot = probe_acked ? bscps_pkg::BOOT_PROBE
                                      : bscps_pkg::BOOT_WAIT_HOST;
            end
            if (s_q.present && eeprom_cfg_loaded) begin
               s_d.boot = bscps_pkg::BOOT_DONE;
            end
         end
         bscps_pkg::BOOT_WAIT_HOST: begin
            if (host_cfg_loaded) begin
               s_d.boot = bscps_pkg::BOOT_DONE;
            end
         end
         bscps_pkg::BOOT_DONE: s_d.loaded = 1'b1;
      endcase
      // Quiet counter restarts on every activity event
      if (s_q.act_b || circuits_busy) begin
         s_d.quiet = 32'h0;
      end else if (s_q.quiet != 32'hFFFF_FFFF) begin
         s_d.quiet = s_q.quiet + 32'h1;
      end
      unique case (s_q.pwr)
         bscps_pkg::PWR_ACTIVE: begin
            if (s_q.quiet >= IDLE_CYCLES) begin
               s_d.pwr = bscps_pkg::PWR_IDLE;
            end
         end
         bscps_pkg::PWR_IDLE: begin
            if (s_q.act_b || circuits_busy) begin
               s_d.pwr = bscps_pkg::PWR_ACTIVE;
            end else if (s_q.quiet >= SLEEP_CYCLES && !s_q.att_b) begin
               s_d.pwr = bscps_pkg::PWR_SLEEP;
            end
         end
         bscps_pkg::PWR_SLEEP: begin
            if (s_q.att_b || s_q.act_b || circuits_busy) begin
               s_d.pwr = bscps_pkg::PWR_ACTIVE;
               s_d.quiet = 32'h0;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_q <= '{s1a: 3'h0, s1b: 3'h0, s2a: 3'h0, s2b: 3'h0, idx: 3'h0,
                  pol: 3'(bscps_pkg::POL_NO_SINK),
                  boot: bscps_pkg::BOOT_STRAP,
                  pwr: bscps_pkg::PWR_ACTIVE,
                  quiet: 32'h0, probe_go: 1'b0, present: 1'b0,
                  loaded: 1'b0, act_a: 1'b0, act_b: 1'b0,
                  att_a: 1'b0, att_b: 1'b0, settle: 2'h0,
                  sda_a: 1'b1, sda_b: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************
   // Registered outputs
   // ************************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         eeprom_scl_out <= 1'b1;
         eeprom_scl_oe <= 1'b0;
         eeprom_sda_oe <= 1'b0;
         addr_index <= 3'h0;
         policy <= 3'(bscps_pkg::POL_NO_SINK);
         port_a_addr <= bscps_pkg::HOST_ADDR_BASE;
         port_b_addr <= bscps_pkg::HOST_ADDR_BASE | bscps_pkg::PORT_B_BIT;
         port_b_enable <= 1'b0;
         sink_enable <= 1'b0;
         sink_needs_3a <= 1'b0;
         sink_needs_1a5 <= 1'b0;
         pd_enable <= 1'b0;
         app_state <= 1'b0;
         eeprom_present <= 1'b0;
         cfg_loaded <= 1'b0;
         power_state <= 2'h0;
      end else begin
         eeprom_scl_out <= scl_w;
         eeprom_scl_oe <= scl_oe_w;
         eeprom_sda_oe <= sda_oe_w;
         addr_index <= s_q.idx;
         policy <= s_q.pol;
         // Index 1..4 maps onto the two low address bits
         port_a_addr <= bscps_pkg::HOST_ADDR_BASE
                        | {5'h00, 2'(s_q.idx - 3'h1)};
         port_b_addr <= bscps_pkg::HOST_ADDR_BASE | bscps_pkg::PORT_B_BIT
                        | {5'h00, 2'(s_q.idx - 3'h1)};
         port_b_enable <= s_q.loaded;
         // Current-qualified policies rely on the two need flags instead
         sink_enable <= s_q.pol == 3'(bscps_pkg::POL_UNCOND)
                        || s_q.pol == 3'(bscps_pkg::POL_HIGH_VOLT);
         sink_needs_3a <= s_q.pol == 3'(bscps_pkg::POL_THREE_AMP);
         sink_needs_1a5 <= s_q.pol == 3'(bscps_pkg::POL_ONE_HALF_AMP);
         pd_enable <= s_q.loaded
                      || s_q.pol == 3'(bscps_pkg::POL_HIGH_VOLT);
         app_state <= s_q.loaded
                      || s_q.pol == 3'(bscps_pkg::POL_HIGH_VOLT);
         eeprom_present <= s_q.present;
         cfg_loaded <= s_q.loaded;
         power_state <= 2'(s_q.pwr);
      end
   end
endmodule : bscps_top

// ---- bscps_pkg.sv ----
// Package: constants for boot strap decode, EEPROM probe and power states
package bscps_pkg;
   localparam logic [6:0] EEPROM_ADDR = 7'h50;
   localparam logic [6:0] HOST_ADDR_BASE = 7'h20;
   localparam logic [6:0] PORT_B_BIT = 7'h04;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned I2C_HZ = 100000;
   localparam int unsigned SCL_DIV = CLK_HZ / (I2C_HZ * 4);
   localparam int unsigned IDLE_CYCLES = 100000;
   localparam int unsigned SLEEP_CYCLES = 400000;
   typedef enum logic [2:0] {
      POL_UNCOND, POL_THREE_AMP, POL_ONE_HALF_AMP, POL_HIGH_VOLT, POL_NO_SINK
   } bscps_policy_t;
   typedef enum {
      BOOT_STRAP, BOOT_PROBE, BOOT_WAIT_HOST, BOOT_DONE
   } bscps_boot_t;
   typedef enum {
      PWR_ACTIVE, PWR_IDLE, PWR_SLEEP
   } bscps_pwr_t;
endpackage : bscps_pkg

// ---- bscps_probe.sv ----
// EEPROM presence probe: start, address byte, ack sample, stop
`timescale 1ns/10ps
module bscps_probe (
   input wire logic mclk, // Core clock
   input wire logic reset, // Synchronous reset, active high
   input wire logic start, // One-cycle request to probe
   input wire logic sda_in, // Synchronised data line level
   output logic scl_out, // Clock line level (low = drive low)
   output logic scl_oe, // Clock line drive enable
   output logic sda_oe, // Data line pull-low enable
   output logic done, // One-cycle pulse when probe ends
   output logic acked // Eeprom acknowledged the address
);
   typedef struct packed {
      logic busy;
      logic [7:0] div;
      logic [1:0] ph;
      logic [4:0] bit_n;
      logic scl;
      logic sda_lo;
      logic done;
      logic acked;
   } bscps_probe_st_t;
   bscps_probe_st_t s_q, s_d;
   logic [7:0] shift;

   // Address plus write bit, sent msb first
   assign shift = {bscps_pkg::EEPROM_ADDR, 1'b0};

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (start && !s_q.busy) begin
         s_d.busy = 1'b1;
         s_d.bit_n = 5'h00;
         s_d.ph = 2'h0;
         s_d.div = 8'h00;
         s_d.sda_lo = 1'b1; // Start: data falls while clock high
         s_d.scl = 1'b1;
      end else if (s_q.busy) begin
         if (s_q.div == 8'(bscps_pkg::SCL_DIV - 1)) begin
            s_d.div = 8'h00;
            s_d.ph = s_q.ph + 2'h1;
            unique case (s_q.ph)
               2'h0: s_d.scl = 1'b0;
               2'h1: begin
                  if (s_q.bit_n < 5'h08) begin
                     s_d.sda_lo = !shift[3'(5'h07 - s_q.bit_n)];
                  end else if (s_q.bit_n == 5'h08) begin
                     s_d.sda_lo = 1'b0; // Release for ack
                  end else begin
                     s_d.sda_lo = 1'b1; // Prepare stop
                  end
               end
               2'h2: begin
                  s_d.scl = 1'b1;
                  if (s_q.bit_n == 5'h08) begin
                     s_d.acked = !sda_in;
                  end
               end
               2'h3: begin
                  s_d.bit_n = s_q.bit_n + 5'h01;
                  if (s_q.bit_n == 5'h09) begin
                     s_d.sda_lo = 1'b0; // Stop: data rises with clock high
                     s_d.busy = 1'b0;
                     s_d.done = 1'b1;
                  end
               end
            endcase
         end else begin
            s_d.div = s_q.div + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_q <= '{busy: 1'b0, div: 8'h00, ph: 2'h0, bit_n: 5'h00,
                  scl: 1'b1, sda_lo: 1'b0, done: 1'b0, acked: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign scl_out = s_q.scl;
   assign scl_oe = !s_q.scl;
   assign sda_oe = s_q.sda_lo;
   assign done = s_q.done;
   assign acked = s_q.acked;
endmodule : bscps_probe

// ---- bscps_top_props.sv ----
// Checker: strap decode, boot address and power state assertions
`timescale 1ns/10ps
module bscps_top_props #(
   parameter int unsigned IDLE_CYCLES = 20
) (
   input wire logic mclk, // Core clock
   input wire logic reset, // Synchronous reset
   input wire logic activity, // Activity event
   input wire logic attach, // Attach detected
   input wire logic [2:0] addr_index, // Address index
   input wire logic [2:0] policy, // Sink policy
   input wire logic [6:0] port_a_addr, // Port A address
   input wire logic [6:0] port_b_addr, // Port B address
   input wire logic port_b_enable, // Port B responds
   input wire logic sink_enable, // Sink path enable
   input wire logic pd_enable, // PD enable
   input wire logic app_state, // Firmware state
   input wire logic cfg_loaded, // Configuration loaded
   input wire logic [1:0] power_state // Power state
);
   // ****************************************
   // Quiet counter, counts raw inputs so it never lags the design
   // ****************************************
   int unsigned quiet_q;
   always_ff @(posedge mclk) begin
      if (reset || activity) begin
         quiet_q <= 0;
      end else if (quiet_q < 32'h000F_FFFF) begin
         quiet_q <= quiet_q + 1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   a_one_state: assert property (
      power_state inside {2'h0, 2'h1, 2'h2}) else $error("bad power state");
   a_addr_map: assert property (
      addr_index != 3'h0 |-> port_a_addr == 7'(7'h1F + addr_index)
      && port_b_addr == (port_a_addr | 7'h04)) else $error("bad address");
   a_boot_port_b: assert property (
      !cfg_loaded |-> !port_b_enable) else $error("port B live in boot");
   a_policy_fixed: assert property (
      addr_index != 3'h0 && $past(addr_index) != 3'h0 |-> $stable(policy))
      else $error("policy changed after boot");
   a_no_sink_off: assert property (
      policy == 3'h4 && $past(policy, 2) == 3'h4 && !cfg_loaded
      |-> !sink_enable && !pd_enable) else $error("no-sink policy leaks");
   a_uncond_sink: assert property (
      policy == 3'h0 && $past(policy, 2) == 3'h0 && !cfg_loaded
      |-> sink_enable && !pd_enable) else $error("uncond sink wrong");
   a_cond_sink: assert property (
      policy inside {3'h1, 3'h2} |-> !sink_enable)
      else $error("conditional sink enabled unqualified");
   a_high_volt: assert property (
      policy == 3'h3 && $past(policy, 2) == 3'h3
      |-> sink_enable && pd_enable && app_state) else $error("hv wrong");
   a_idle_quiet: assert property (
      $past(power_state) == 2'h0 && power_state == 2'h1
      |-> quiet_q >= IDLE_CYCLES) else $error("idle too early");
   a_sleep_wake: assert property (
      power_state == 2'h2 && attach |-> ##[1:6] power_state == 2'h0)
      else $error("no wake on attach");
endmodule : bscps_top_props

bind bscps_top bscps_top_props #(.IDLE_CYCLES(IDLE_CYCLES)) u_props (
   .mclk(mclk), .reset(reset), .activity(activity), .attach(attach),
   .addr_index(addr_index), .policy(policy), .port_a_addr(port_a_addr),
   .port_b_addr(port_b_addr), .port_b_enable(port_b_enable),
   .sink_enable(sink_enable), .pd_enable(pd_enable),
   .app_state(app_state), .cfg_loaded(cfg_loaded),
   .power_state(power_state));

// ---- bscps_eeprom_model.sv ----
// Configuration EEPROM model: acknowledges its address byte only
`timescale 1ns/10ps
module bscps_eeprom_model #(
   parameter logic [6:0] DEV_ADDR = 7'h50
) (
   input wire logic scl, // Clock line level
   input wire logic sda, // Data line level
   input wire logic present, // Device fitted on the bus
   output logic sda_oe, // Data pull-low enable
   output logic [7:0] addr_byte // Last address byte seen
);
   int bits;
   logic [7:0] sh;
   initial begin
      sda_oe = 1'b0;
      bits = 9;
      sh = 8'h00;
      addr_byte = 8'h00;
   end
   always @(negedge sda) begin
      if (scl) begin
         bits = 0;
      end
   end
   always @(posedge scl) begin
      if (bits < 8) begin
         sh = {sh[6:0], sda};
      end
      bits = bits + 1;
   end
   // Own bus only, so only our own address is ever answered
   always @(negedge scl) begin
      if (bits == 8) begin
         addr_byte = sh;
         sda_oe = present && sh == {DEV_ADDR, 1'b0};
      end else begin
         sda_oe = 1'b0;
      end
   end
endmodule : bscps_eeprom_model

// ---- boot_strap_config_power_states_test.sv ----
// Testbench: strap table, EEPROM or host load, power states
`timescale 1ns/10ps
module boot_strap_config_power_states_test;
   logic mclk = 1'b0, reset = 1'b1, e_ld = 1'b0, h_ld = 1'b0;
   logic activity = 1'b0, attach = 1'b0, busy = 1'b0, present = 1'b0;
   logic [2:0] s1 = 3'h7, s2 = 3'h0, addr_index, policy;
   logic scl_out, scl_oe, sda_oe, e_oe, port_b_enable, sink_enable;
   logic n3a, n1a5, pd_enable, app_state, eeprom_present, cfg_loaded;
   logic [6:0] pa, pb;
   logic [1:0] power_state;
   logic [7:0] addr_byte;
   int num_errors = 0, n_checks = 0;
   wire scl = !(scl_oe && !scl_out);
   wire sda = !(sda_oe || e_oe);
   always #25 mclk = ~mclk;
   bscps_top #(.IDLE_CYCLES(20), .SLEEP_CYCLES(40)) dut (
      .mclk(mclk), .reset(reset), .strap_input_one(s1),
      .strap_input_two(s2), .eeprom_sda_in(sda), .eeprom_cfg_loaded(e_ld),
      .host_cfg_loaded(h_ld), .activity(activity), .attach(attach),
      .circuits_busy(busy), .eeprom_scl_out(scl_out), .eeprom_scl_oe(scl_oe),
      .eeprom_sda_oe(sda_oe), .addr_index(addr_index), .policy(policy),
      .port_a_addr(pa), .port_b_addr(pb), .port_b_enable(port_b_enable),
      .sink_enable(sink_enable), .sink_needs_3a(n3a), .sink_needs_1a5(n1a5),
      .pd_enable(pd_enable), .app_state(app_state),
      .eeprom_present(eeprom_present), .cfg_loaded(cfg_loaded),
      .power_state(power_state));
   bscps_eeprom_model u_eeprom (.scl(scl), .sda(sda), .present(present),
      .sda_oe(e_oe), .addr_byte(addr_byte));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   // Straps settle under reset, well ahead of release
   task automatic boot(input logic [5:0] st, input logic fit);
      reset = 1'b1;
      {s1, s2} = st;
      present = fit;
      tick(4);
      reset = 1'b0;
      tick(1);
   endtask : boot
   task automatic test_straps();
      logic [5:0] tab [20] = '{6'h3D, 6'h2D, 6'h10, 6'h0F, 6'h3C, 6'h24,
         6'h18, 6'h17, 6'h3E, 6'h36, 6'h35, 6'h37, 6'h3B, 6'h1B, 6'h20,
         6'h1F, 6'h38, 6'h00, 6'h30, 6'h2F};
      int p, x;
      for (int i = 0; i < 21; i++) begin
         p = (i < 20) ? i / 4 : 4;
         x = (i < 20) ? i % 4 + 1 : 0;
         boot((i < 20) ? tab[i] : 6'h3F, 1'b0);
         tick(5);
         check(8'(policy), 8'(p));
         check(8'(addr_index), 8'(x));
         if (x != 0) begin
            check(8'(pa), 8'(7'h1F + x));
            check(8'(pb), 8'(7'h1F + x) | 8'h04);
         end
         check(8'(port_b_enable), 8'h00);
         check(8'(sink_enable), 8'(p == 0 || p == 3));
         check(8'(n3a), 8'(p == 1));
         check(8'(n1a5), 8'(p == 2));
         check(8'({pd_enable, app_state}), (p == 3) ? 8'h03 : 8'h00);
      end
   endtask : test_straps
   task automatic pulse(input logic host);
      if (host) h_ld = 1'b1;
      else e_ld = 1'b1;
      tick(1);
      {h_ld, e_ld} = 2'h0;
      tick(3);
   endtask : pulse
   task automatic test_eeprom();
      boot(6'h38, 1'b1);
      pulse(1'b0);
      check(8'(cfg_loaded), 8'h00);
      for (int k = 0; k < 3000 && eeprom_present !== 1'b1; k++) tick(1);
      check(8'(eeprom_present), 8'h01);
      check(addr_byte, 8'hA0);
      pulse(1'b1);
      check(8'(cfg_loaded), 8'h00);
      pulse(1'b0);
      check(8'({cfg_loaded, port_b_enable, pd_enable}), 8'h07);
   endtask : test_eeprom
   task automatic test_host_power();
      boot(6'h3D, 1'b0);
      tick(2500);
      check(8'(eeprom_present), 8'h00);
      pulse(1'b0);
      check(8'(cfg_loaded), 8'h00);
      pulse(1'b1);
      check(8'(cfg_loaded), 8'h01);
      activity = 1'b1;
      tick(2);
      activity = 1'b0;
      tick(18);
      check(8'(power_state), 8'h00);
      for (int k = 0; k < 60 && power_state !== 2'h1; k++) tick(1);
      check(8'(power_state), 8'h01);
      for (int k = 0; k < 100 && power_state !== 2'h2; k++) tick(1);
      check(8'(power_state), 8'h02);
      attach = 1'b1;
      tick(6);
      check(8'(power_state), 8'h00);
      attach = 1'b0;
      busy = 1'b1;
      tick(100);
      check(8'(power_state), 8'h00);
      busy = 1'b0;
   endtask : test_host_power
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   initial begin
      #2000000;
      num_errors++;
      conclude();
   end
   initial begin
      tick(10);
      test_straps();
      test_eeprom();
      test_host_power();
      conclude();
   end
endmodule : boot_strap_config_power_states_test
